// file: hdl/stl_pkg.sv
// Constants and types for the strap latch and test mode select block
//
// How it works
// RULE1 - Each strap pin level is caught at the rising edge of power-good and picks the setup.
// RULE2 - The board holds a strap level for at least four PCI clocks before that edge.
// RULE3 - After capture the pins go back to normal use and the caught setup stays in force.
// RULE4 - The audio serial out strap caught high drives the processor speed straps to safe.
// RULE5 - The caught safe strap reads as bit 2 of the strap status word at D4h.
// RULE6 - Grant A caught low turns on boot-block swap, inverting address bit 16 on BIOS cycles.
// RULE7 - The swap state reads as bit 13 of the strap status word at D4h.
// RULE8 - While grant A was caught low software cannot clear swap until a boot without it.
// RULE9 - The hub compensation pin is sampled in PCI reset: high normal, low enhanced buffers.
// RULE10 - The speaker strap caught low stops the watchdog from rebooting the system.
// RULE11 - The caught no-reboot strap reads as bit 1 of the strap status word at D4h.
// RULE12 - With power-good high, PCI clocks with the RTC reset pin low are counted.
// RULE13 - Count below 4 none, 4 to 7 XOR chain 1 to 4, 8 all float, above 24 none.
// RULE14 - The tester never holds the RTC reset pin low for 9 to 24 PCI clocks.
// RULE15 - The tester starts the test pulse only after PCI reset is released.
// RULE16 - Caught straps sit in flops and stay fixed until the next power-good rise.
// RULE17 - The count is decoded when the RTC reset pin returns high.
package stl_pkg;
    // Register byte offsets
    localparam logic [7:0] STL_OFS_STRAP     = 8'hD4;
    localparam logic [7:0] STL_OFS_TEST      = 8'hD8;
    // Strap status word fields
    localparam int         STL_BIT_NO_REBOOT = 1;
    localparam int         STL_BIT_SAFE_MODE = 2;
    localparam int         STL_BIT_TOP_SWAP  = 13;
    // Test status word fields
    localparam int         STL_BIT_HUB_ENH   = 0;
    localparam int         STL_BIT_TEST_LSB  = 1;
    localparam int         STL_BIT_FLOAT     = 4;
    localparam int         STL_BIT_STRAP_PH  = 5;
    // Values after reset
    localparam logic       STL_RST_SAFE      = 1'b0;
    localparam logic       STL_RST_NO_REBOOT = 1'b0;
    localparam logic       STL_RST_SWAP      = 1'b0;
    localparam logic       STL_RST_HUB_ENH   = 1'b0;
    localparam logic       STL_RST_STRAP_PH  = 1'b1;
    // Strap setup time in PCI clocks
    localparam int         STL_STRAP_SETUP   = 4;
    // Test pulse counter
    localparam int         STL_CNT_W         = 5;
    localparam logic [4:0] STL_CNT_MAX       = 5'h1F;
    localparam logic [4:0] STL_CNT_XOR_MIN   = 5'h04;
    localparam logic [4:0] STL_CNT_XOR_MAX   = 5'h07;
    localparam logic [4:0] STL_CNT_ALLZ      = 5'h08;
    localparam logic [4:0] STL_CNT_RSV_MAX   = 5'h18;

    typedef enum logic [2:0] {
        STL_TM_NONE = 3'h0,
        STL_TM_XOR1 = 3'h1,
        STL_TM_XOR2 = 3'h2,
        STL_TM_XOR3 = 3'h3,
        STL_TM_XOR4 = 3'h4,
        STL_TM_ALLZ = 3'h5
    } stl_test_e;

    typedef enum logic [1:0] {
        STL_ST_IDLE  = 2'b01,
        STL_ST_COUNT = 2'b10
    } stl_dec_st_e;
endpackage : stl_pkg

// file: hdl/stl_rise_det.sv
// Rising edge detector for a level sampled on the system clock
module stl_rise_det (
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    input  wire logic i_level,
    output logic      o_rise
);
    import stl_pkg::*;

    logic level_r;

    // Previous sample; inputs are already synchronous
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            level_r <= 1'b0;
        end else begin
            level_r <= i_level;
        end
    end

    // High for one cycle on each low to high step
    assign o_rise = i_level & ~level_r;

endmodule : stl_rise_det

// file: hdl/stl_test_decode.sv
// Test mode pulse counter and decoder on the RTC well reset pin
module stl_test_decode (
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    input  wire logic        i_pci_tick,
    input  wire logic        i_power_good,
    input  wire logic        i_pci_reset_b,
    input  wire logic        i_rtc_low,
    output stl_pkg::stl_test_e o_mode,
    output logic             o_float
);
    import stl_pkg::*;

    stl_dec_st_e          st_r;
    logic [STL_CNT_W-1:0] cnt_r;
    logic                 release_w;

    assign release_w = (st_r == STL_ST_COUNT) && !i_rtc_low && i_power_good;

    // Count PCI clocks while the pin is held low
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r  <= STL_ST_IDLE;
            cnt_r <= '0;
        end else if (!i_power_good) begin
            st_r  <= STL_ST_IDLE;
            cnt_r <= '0;
        end else begin
            unique case (st_r)
                STL_ST_IDLE: begin
                    cnt_r <= '0;
                    if (i_rtc_low && i_pci_reset_b) begin // [RULE15]
                        st_r <= STL_ST_COUNT;
                    end
                end
                STL_ST_COUNT: begin
                    if (!i_rtc_low) begin
                        st_r <= STL_ST_IDLE;
                    end else if (i_pci_tick && cnt_r != STL_CNT_MAX) begin
                        cnt_r <= cnt_r + 5'h01; // Saturates at 31 [RULE12]
                    end
                end
            endcase
        end
    end

    // Decode only on release, so long pulses fall to no test
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_mode  <= STL_TM_NONE;
            o_float <= 1'b0;
        end else if (!i_power_good) begin
            o_mode  <= STL_TM_NONE;
            o_float <= 1'b0;
        end else if (release_w) begin // [RULE17]
            o_float <= (cnt_r == STL_CNT_ALLZ);
            if (cnt_r >= STL_CNT_XOR_MIN && cnt_r <= STL_CNT_XOR_MAX) begin // [RULE13]
                o_mode <= stl_test_e'(cnt_r[2:0] - 3'h3);
            end else if (cnt_r == STL_CNT_ALLZ) begin
                o_mode <= STL_TM_ALLZ;
            end else begin
                o_mode <= STL_TM_NONE; // Reserved counts land here too [RULE14]
            end
        end
    end

    a_count_step: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE12]
        st_r == STL_ST_COUNT && i_rtc_low && i_power_good && i_pci_tick
        && cnt_r < STL_CNT_MAX |=> cnt_r == $past(cnt_r) + 5'h01)
        else $error("test pulse count did not step");

    a_xor_decode: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE13]
        release_w && cnt_r == 5'h04 |=> o_mode == STL_TM_XOR1 && !o_float)
        else $error("count of four did not select xor chain one");

    a_long_none: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE17]
        release_w && (cnt_r < 5'h04 || cnt_r > 5'h18) |=> o_mode == STL_TM_NONE)
        else $error("short or long pulse selected a test");

    a_float_eight: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE13]
        release_w && cnt_r == 5'h08 |=> o_float && o_mode == STL_TM_ALLZ)
        else $error("count of eight did not float outputs");

endmodule : stl_test_decode

// file: hdl/stl_top.sv
// Strap latch, strap status registers and test mode select top level
//
// The APB interface to the registers and the test status word at D8h are this design's own decisions.
module stl_top (
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,

    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,

    // Strap and qualifier pins
    input  wire logic        i_power_good_input,
    input  wire logic        i_pci_clock,
    input  wire logic        i_pci_reset_output_b,
    input  wire logic        i_audio_link_serial_out,
    input  wire logic        i_grant_a_b,
    input  wire logic        i_speaker_output_pin,
    input  wire logic        i_hub_buffer_compensation_pin,
    input  wire logic        i_rtc_well_reset_pin_b,

    // Functions steered by the straps
    input  wire logic        i_bios_cycle,
    input  wire logic        i_address_bit_sixteen,
    output logic             o_address_bit_sixteen,
    input  wire logic        i_watchdog_expire,
    output logic             o_system_reboot,
    output logic             o_cpu_speed_safe,
    output logic             o_top_swap,
    output logic             o_hub_enhanced_mode,
    output logic             o_strap_phase,
    output stl_pkg::stl_test_e o_test_mode,
    output logic             o_outputs_float
);
    import stl_pkg::*;

    logic        pg_rise;
    logic        pci_tick;

    logic        safe_r;
    logic        no_reboot_r;
    logic        swap_strap_r;
    logic        top_swap_r;
    logic        hub_enh_r;
    logic        strap_ph_r;

    logic        setup_w;
    logic        access_w;
    logic        wr_strap_w;
    logic        mapped_w;
    logic [31:0] rd_word;

    // Power-good edge starts each capture
    stl_rise_det u_pg_rise (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_level (i_power_good_input),
        .o_rise  (pg_rise)
    );

    // PCI clock is sampled as a plain input; 200 MHz oversamples it
    stl_rise_det u_pci_tick (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_level (i_pci_clock),
        .o_rise  (pci_tick)
    );

    // Test pulse decoder on the RTC well reset pin
    stl_test_decode u_test (
        .i_clock      (i_clock),
        .i_rst_b      (i_rst_b),
        .i_pci_tick   (pci_tick),
        .i_power_good (i_power_good_input),
        .i_pci_reset_b(i_pci_reset_output_b),
        .i_rtc_low    (~i_rtc_well_reset_pin_b),
        .o_mode       (o_test_mode),
        .o_float      (o_outputs_float)
    );

    // Strap role lasts until capture and resumes when power-good drops
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strap_ph_r <= STL_RST_STRAP_PH;
        end else if (pg_rise) begin
            strap_ph_r <= 1'b0; // Pins back to normal use [RULE3]
        end else if (!i_power_good_input) begin
            strap_ph_r <= 1'b1;
        end
    end

    assign o_strap_phase = strap_ph_r;

    // Safe mode and no-reboot straps, caught only at the edge
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            safe_r      <= STL_RST_SAFE;
            no_reboot_r <= STL_RST_NO_REBOOT;
        end else if (pg_rise) begin // [RULE1] [RULE16]
            safe_r      <= i_audio_link_serial_out; // Pulled down, high means safe [RULE4]
            no_reboot_r <= ~i_speaker_output_pin; // Pulled up, low means no reboot [RULE10]
        end
    end

    // Speed straps follow the caught safe bit directly
    assign o_cpu_speed_safe = safe_r; // [RULE4]

    // Grant A strap; the caught level also locks the swap bit
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            swap_strap_r <= STL_RST_SWAP;
        end else if (pg_rise) begin
            swap_strap_r <= ~i_grant_a_b; // [RULE1] [RULE6]
        end
    end

    // Swap bit: set by the strap, software may set it freely
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            top_swap_r <= STL_RST_SWAP;
        end else if (pg_rise) begin
            top_swap_r <= ~i_grant_a_b; // [RULE6]
        end else if (wr_strap_w) begin
            // A pulled-down strap wins over a clearing write [RULE8]
            top_swap_r <= i_pwdata[STL_BIT_TOP_SWAP] | swap_strap_r;
        end
    end

    assign o_top_swap = top_swap_r;

    // Address bit 16 inverted on BIOS cycles while the swap bit is set; one cycle of latency
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_address_bit_sixteen <= 1'b0;
        end else begin
            o_address_bit_sixteen <= i_address_bit_sixteen ^ (i_bios_cycle & top_swap_r); // [RULE6]
        end
    end

    // Watchdog expiry reboots unless the strap forbids it
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_system_reboot <= 1'b0;
        end else begin
            o_system_reboot <= i_watchdog_expire & ~no_reboot_r; // [RULE10]
        end
    end

    // Hub buffer mode tracks the pin while PCI reset is held
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hub_enh_r <= STL_RST_HUB_ENH;
        end else if (!i_pci_reset_output_b) begin
            hub_enh_r <= ~i_hub_buffer_compensation_pin; // Low selects enhanced [RULE9]
        end
    end

    assign o_hub_enhanced_mode = hub_enh_r;

    // APB phase decode
    assign setup_w    = i_psel & ~i_penable;
    assign access_w   = i_psel & i_penable & o_pready;
    assign wr_strap_w = access_w & i_pwrite & (i_paddr == STL_OFS_STRAP);
    assign mapped_w   = (i_paddr == STL_OFS_STRAP) || (i_paddr == STL_OFS_TEST);

    // Read word; reserved bits read as zero
    always_comb begin
        rd_word = '0;
        unique case (i_paddr)
            STL_OFS_STRAP: begin
                rd_word[STL_BIT_NO_REBOOT] = no_reboot_r; // [RULE11]
                rd_word[STL_BIT_SAFE_MODE] = safe_r; // [RULE5]
                rd_word[STL_BIT_TOP_SWAP]  = top_swap_r; // [RULE7]
            end
            STL_OFS_TEST: begin
                rd_word[STL_BIT_HUB_ENH]                     = hub_enh_r;
                rd_word[STL_BIT_TEST_LSB+2:STL_BIT_TEST_LSB] = o_test_mode;
                rd_word[STL_BIT_FLOAT]                       = o_outputs_float;
                rd_word[STL_BIT_STRAP_PH]                    = strap_ph_r;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // One wait-free access: answer in the cycle after setup
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= '0;
        end else begin
            o_pready  <= setup_w;
            o_pslverr <= setup_w & ~mapped_w;
            if (setup_w) begin
                // Data loaded at setup so it is stable through access
                o_prdata <= i_pwrite ? 32'h0000_0000 : rd_word;
            end
        end
    end

    a_safe_capture: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE1]
        pg_rise |=> safe_r == $past(i_audio_link_serial_out)
        && no_reboot_r == !$past(i_speaker_output_pin))
        else $error("straps not caught at power-good rise");

    a_straps_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE16]
        !pg_rise |=> $stable(safe_r) && $stable(no_reboot_r) && $stable(swap_strap_r))
        else $error("caught strap changed without a power-good rise");

    a_phase_ends: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE3]
        pg_rise ##1 i_power_good_input |-> !o_strap_phase)
        else $error("pins still in strap role after capture");

    a_safe_speed: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE4]
        pg_rise && i_audio_link_serial_out |=> o_cpu_speed_safe)
        else $error("safe strap high did not select safe speed");

    a_swap_invert: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE6]
        i_bios_cycle && top_swap_r |=>
        o_address_bit_sixteen == !$past(i_address_bit_sixteen))
        else $error("address bit 16 not inverted in swap mode");

    a_plain_addr: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE6]
        !(i_bios_cycle && top_swap_r) |=>
        o_address_bit_sixteen == $past(i_address_bit_sixteen))
        else $error("address bit 16 changed outside swap");

    a_swap_locked: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE8]
        swap_strap_r && top_swap_r && !pg_rise |=> top_swap_r)
        else $error("swap bit cleared while strap held it");

    a_swap_clear: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE8]
        wr_strap_w && !swap_strap_r && !pg_rise |=>
        top_swap_r == $past(i_pwdata[STL_BIT_TOP_SWAP]))
        else $error("swap bit ignored a permitted write");

    a_hub_sample: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE9]
        !i_pci_reset_output_b |=> hub_enh_r == !$past(i_hub_buffer_compensation_pin))
        else $error("hub buffer mode not sampled in reset");

    a_no_reboot: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE10]
        i_watchdog_expire |=> o_system_reboot == !$past(no_reboot_r))
        else $error("watchdog reboot not gated by strap");

    a_status_read: assert property (@(posedge i_clock) // [RULE5] [RULE7] [RULE11]
        disable iff (!i_rst_b)
        access_w && !i_pwrite && i_paddr == STL_OFS_STRAP |->
        o_prdata[STL_BIT_SAFE_MODE] == $past(safe_r)
        && o_prdata[STL_BIT_NO_REBOOT] == $past(no_reboot_r)
        && o_prdata[STL_BIT_TOP_SWAP] == $past(top_swap_r))
        else $error("strap status word read wrong");

    a_apb_answer: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        setup_w |=> o_pready ##1 !o_pready || setup_w)
        else $error("apb answer not one cycle after setup");

endmodule : stl_top

// file: verif/stl_board_model.sv
// Board strap resistors, PCI clock and test equipment on the strap pins
module stl_board_model (
    input  wire logic i_clock,
    output logic      o_pci_clock,
    output logic      o_power_good,
    output logic      o_pci_reset_b,
    output logic      o_audio_link_serial_out,
    output logic      o_grant_a_b,
    output logic      o_speaker_output_pin,
    output logic      o_hub_buffer_compensation_pin,
    output logic      o_rtc_well_reset_pin_b
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] div_r = 3'h0;

    // Divide by six: 33.3 MHz PCI clock, free running like the board's
    always @(posedge i_clock) begin
        div_r <= (div_r == 3'h5) ? 3'h0 : div_r + 3'h1;
    end
    assign o_pci_clock = (div_r >= 3'h3);

    // Idle board: pulls at rest, power and PCI reset low
    initial begin
        o_power_good                  = 1'b0;
        o_pci_reset_b                 = 1'b0;
        o_audio_link_serial_out       = 1'b0;
        o_grant_a_b                   = 1'b1;
        o_speaker_output_pin          = 1'b1;
        o_hub_buffer_compensation_pin = 1'b1;
        o_rtc_well_reset_pin_b        = 1'b1;
    end

    // Boot with chosen strap levels, then reuse the pins for ordinary traffic
    task automatic power_up(input logic safe, input logic gnt_b, input logic spk,
                            input logic hub);
        @(posedge i_clock);
        o_power_good                  <= 1'b0;
        o_pci_reset_b                 <= 1'b0;
        o_audio_link_serial_out       <= safe;
        o_grant_a_b                   <= gnt_b;
        o_speaker_output_pin          <= spk;
        o_hub_buffer_compensation_pin <= hub;
        repeat (30) @(posedge i_clock); // Five PCI clocks of setup
        o_power_good <= 1'b1;
        repeat (12) @(posedge i_clock);
        o_pci_reset_b <= 1'b1;
        // Pins now toggle every cycle; a latch that follows them is caught
        repeat (9) begin
            @(posedge i_clock);
            o_audio_link_serial_out       <= ~o_audio_link_serial_out;
            o_grant_a_b                   <= ~o_grant_a_b;
            o_speaker_output_pin          <= ~o_speaker_output_pin;
            o_hub_buffer_compensation_pin <= ~o_hub_buffer_compensation_pin;
        end
    endtask : power_up

    // Low pulse spanning exactly n PCI rises, edges kept on PCI clock falls
    task automatic rtc_pulse(input int n);
        if (o_pci_reset_b !== 1'b1) begin // Only after PCI reset ends
            return;
        end
        // Start on an edge so the pin never moves between clock edges
        @(posedge i_clock);
        for (int k = 0; k < 6 && div_r != 3'h5; k++) begin
            @(posedge i_clock);
        end
        o_rtc_well_reset_pin_b <= 1'b0;
        repeat (6 * n) @(posedge i_clock);
        o_rtc_well_reset_pin_b <= 1'b1;
    endtask : rtc_pulse
endmodule : stl_board_model

// file: verif/tb_strap_latch_test_mode_select.sv
// Self-checking bench for the strap latch and test mode select block
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
module tb_strap_latch_test_mode_select;
    timeunit 1ns;
    timeprecision 100ps;
    import stl_pkg::*;
    logic i_clock = 1'b0, i_rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, bios = 1'b0, a16 = 1'b0, a16_o, wd = 1'b0, reboot;
    logic pci_clk, pg, prst_b, safe_pin, gnt_b, spk, hub, rtc_b;
    logic cpu_safe, swap, hub_enh, strap_ph, flt;
    stl_test_e tmode;
    int errors = 0, n_tests = 0;

    always #2.5 i_clock = ~i_clock;

    stl_board_model board (.i_clock(i_clock), .o_pci_clock(pci_clk), .o_power_good(pg),
        .o_pci_reset_b(prst_b), .o_audio_link_serial_out(safe_pin), .o_grant_a_b(gnt_b),
        .o_speaker_output_pin(spk), .o_hub_buffer_compensation_pin(hub),
        .o_rtc_well_reset_pin_b(rtc_b));

    stl_top uut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_power_good_input(pg),
        .i_pci_clock(pci_clk), .i_pci_reset_output_b(prst_b),
        .i_audio_link_serial_out(safe_pin), .i_grant_a_b(gnt_b),
        .i_speaker_output_pin(spk), .i_hub_buffer_compensation_pin(hub),
        .i_rtc_well_reset_pin_b(rtc_b), .i_bios_cycle(bios), .i_address_bit_sixteen(a16),
        .o_address_bit_sixteen(a16_o), .i_watchdog_expire(wd), .o_system_reboot(reboot),
        .o_cpu_speed_safe(cpu_safe), .o_top_swap(swap), .o_hub_enhanced_mode(hub_enh),
        .o_strap_phase(strap_ph), .o_test_mode(tmode), .o_outputs_float(flt));

    task automatic end_of_test;
        $display("Counts: %0d checks, %0d mismatches", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wdat);
        int k;
        @(posedge i_clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wdat;
        @(posedge i_clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            errors++;
            $display("[FAIL] t=%0t APB answer missing", $time);
            end_of_test();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Watchdog expiry and a BIOS cycle, judged one cycle later
    task automatic check_paths(input logic exp_reboot, input logic exp_flip);
        @(posedge i_clock);
        wd   <= 1'b1;
        bios <= 1'b1;
        a16  <= 1'b0;
        @(posedge i_clock);
        #1;
        `CHK(reboot, exp_reboot)
        `CHK(a16_o, exp_flip)
        @(posedge i_clock);
        wd   <= 1'b0;
        bios <= 1'b0;
        a16  <= 1'b1;
        @(posedge i_clock);
        #1;
        `CHK(reboot, 1'b0)
        `CHK(a16_o, 1'b1)
    endtask : check_paths

    function automatic stl_test_e exp_mode(input int n);
        if (n >= 4 && n <= 7) begin
            return stl_test_e'(3'(n - 3));
        end
        return (n == 8) ? STL_TM_ALLZ : STL_TM_NONE;
    endfunction : exp_mode

    task automatic t_reset;
        #1;
        `CHK(strap_ph, 1'b1)
        `CHK(tmode, STL_TM_NONE)
        apb(1'b0, STL_OFS_STRAP, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, STL_OFS_TEST, 32'h0);
        `CHK(rd, 32'h0000_0020)
        $display("test reset done");
    endtask : t_reset

    // All straps at their active levels, pins toggled afterwards
    task automatic t_active_boot;
        board.power_up(1'b1, 1'b0, 1'b0, 1'b0);
        #1;
        `CHK(cpu_safe, 1'b1)
        `CHK(swap, 1'b1)
        `CHK(hub_enh, 1'b1)
        `CHK(strap_ph, 1'b0)
        apb(1'b0, STL_OFS_STRAP, 32'h0);
        `CHK(rd, 32'h0000_2006)
        apb(1'b1, STL_OFS_STRAP, 32'h0);
        apb(1'b0, STL_OFS_STRAP, 32'h0);
        `CHK(rd, 32'h0000_2006)
        apb(1'b0, STL_OFS_TEST, 32'h0);
        `CHK(rd, 32'h0000_0001)
        check_paths(1'b0, 1'b1);
        `CHK(cpu_safe, 1'b1)
        $display("test active boot done");
    endtask : t_active_boot

    // Reboot with straps at rest: swap becomes software writable again
    task automatic t_default_boot;
        board.power_up(1'b0, 1'b1, 1'b1, 1'b1);
        #1;
        `CHK(cpu_safe, 1'b0)
        `CHK(hub_enh, 1'b0)
        apb(1'b0, STL_OFS_STRAP, 32'h0);
        `CHK(rd, 32'h0000_0000)
        check_paths(1'b1, 1'b0);
        apb(1'b1, STL_OFS_STRAP, 32'hFFFF_FFFF);
        apb(1'b0, STL_OFS_STRAP, 32'h0);
        `CHK(rd, 32'h0000_2000)
        `CHK(swap, 1'b1)
        apb(1'b1, STL_OFS_STRAP, 32'h0);
        apb(1'b0, STL_OFS_STRAP, 32'h0);
        `CHK(rd, 32'h0000_0000)
        $display("test default boot done");
    endtask : t_default_boot

    // Pulse lengths skip 9 to 24, which the tester never sends
    task automatic t_test_modes;
        int lens[8] = '{4, 5, 6, 7, 8, 30, 2, 8};
        foreach (lens[i]) begin
            board.rtc_pulse(lens[i]);
            repeat (6) @(posedge i_clock);
            #1;
            `CHK(tmode, exp_mode(lens[i]))
            `CHK(flt, (lens[i] == 8))
        end
        apb(1'b0, STL_OFS_TEST, 32'h0);
        `CHK(rd, 32'h0000_001A)
        $display("test modes done");
    endtask : t_test_modes

    // Power-good drop ends the test mode; unmapped place is refused
    task automatic t_drop_and_unmapped;
        @(posedge i_clock);
        board.o_power_good <= 1'b0;
        repeat (4) @(posedge i_clock);
        #1;
        `CHK(tmode, STL_TM_NONE)
        `CHK(strap_ph, 1'b1)
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        `CHK(err, 1'b1)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0000_0000)
        $display("test drop and unmapped done");
    endtask : t_drop_and_unmapped

    initial begin
        repeat (16) @(posedge i_clock);
        i_rst_b <= 1'b1;
        @(posedge i_clock);
        t_reset();
        t_active_boot();
        t_default_boot();
        t_test_modes();
        t_drop_and_unmapped();
        end_of_test();
    end
endmodule : tb_strap_latch_test_mode_select
